/* design/etx_pkg.sv */
// Functional notes
// - Client words big-endian, start MSB, end anywhere
// - Narrow bus start accepted at any word
// - Octets leave low-order bit first
// - Transmitter inserts gap, delimiters, zero padding
// - Transmitter computes and appends frame check
// - No idles inside a started packet
// - Inputs ignored, idles sent between packets
// - No upper limit on idles between packets
// - Preamble first, header and payload, check last
// - PHY lanes little-endian, lane 0 earliest
// - Address octet 47:40 sent first
// - First bit: low bit of first octet
// - Address bit 40 multicast, bit 41 local
// - Pass-through preamble precedes destination address
// - Addresses keep order under pass-through
// - Accept output marks narrow data taken
// - Narrow bus runs 312.5 or 390.625 MHz; here mclk_in has MCLK_PERIOD_NS of 5.0 (200 MHz)
// - Error on end cycle corrupts the packet
package etx_pkg;

  localparam int unsigned WORD_BITS   = 64;
  localparam int unsigned EMPTY_BITS  = 3;
  localparam int unsigned FIFO_DEPTH  = 16;

  localparam real NARROW_40G_MHZ  = 312.5;
  localparam real NARROW_100G_MHZ = 390.625;
  localparam real MCLK_PERIOD_NS  = 5.0;

  localparam logic [7:0]  CHAR_IDLE   = 8'h07;
  localparam logic [7:0]  CHAR_START  = 8'hFB;
  localparam logic [7:0]  CHAR_TERM   = 8'hFD;
  localparam logic [7:0]  PREAMBLE_B  = 8'h55;
  localparam logic [7:0]  START_DELIM = 8'hD5;
  localparam logic [15:0] MIN_PAYLOAD = 16'h003C;
  localparam logic [3:0]  PRE_LAST    = 4'h7;
  localparam logic [3:0]  FCS_LAST    = 4'h3;
  localparam logic [3:0]  IPG_LAST    = 4'hB;
  localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;

  typedef struct packed {
    logic [WORD_BITS-1:0]  data;
    logic                  sop;
    logic                  eop;
    logic [EMPTY_BITS-1:0] empty;
    logic                  err;
  } etx_word_s;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  ctrl;
  } etx_xgmii_s;

  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_PRE  = 7'b000_0010,
    S_DATA = 7'b000_0100,
    S_PAD  = 7'b000_1000,
    S_FCS  = 7'b001_0000,
    S_TERM = 7'b010_0000,
    S_IPG  = 7'b100_0000
  } etx_state_e;

endpackage

/* design/etx_fifo.sv */
`timescale 1ns/1ps
module etx_fifo import etx_pkg::*; #(
  parameter int unsigned WIDTH = 70,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem[rd_q];
  assign push          = ce_in && in_valid_in && in_ready_out;
  assign pop           = ce_in && out_valid_out && out_ready_in;

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* design/etx_crc32.sv */
`timescale 1ns/1ps
module etx_crc32 import etx_pkg::*; (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  // Byte stream
  input  wire logic        init_in,
  input  wire logic        en_in,
  input  wire logic [7:0]  byte_in,
  output logic [31:0]      crc_out
);
  // Reflected form, so each byte is folded in low bit first as it goes on the wire.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      crc_out <= CRC_INIT;
    end else if (ce_in) begin
      if (init_in) begin
        crc_out <= CRC_INIT;
      end else if (en_in) begin
        crc_out <= crc_byte(crc_out, byte_in);
      end
    end
  end
endmodule

/* design/etx_mac_tx.sv */
`timescale 1ns/1ps
module etx_mac_tx import etx_pkg::*; #(
  parameter int unsigned WORDS         = 4,
  parameter int unsigned DEPTH         = FIFO_DEPTH,
  parameter bit          PREAMBLE_PASS = 1'b0
) (
  // Clock, reset and enable
  input  wire logic                       mclk_in,
  input  wire logic                       reset_in,
  input  wire logic                       ce_in,
  // Narrow client bus
  input  wire logic [WORDS*WORD_BITS-1:0] din_in,
  input  wire logic [WORDS-1:0]           din_sop_in,
  input  wire logic [WORDS-1:0]           din_eop_in,
  input  wire logic [WORDS*3-1:0]         din_eop_empty_in,
  input  wire logic [WORDS-1:0]           din_idle_in,
  input  wire logic [WORDS-1:0]           tx_error_in,
  output logic                            din_req_out,
  // PHY side
  output etx_xgmii_s                      xgmii_out,
  output logic                            xgmii_valid_out,
  // Frame status
  output logic                            dest_multicast_out,
  output logic                            dest_local_out
);
  localparam int unsigned WB = $bits(etx_word_s);

  etx_word_s        hold_q [WORDS];
  logic [WORDS-1:0] hold_v_q;
  logic [WORDS-1:0] sel;
  etx_word_s        push_w;
  logic             push_v;
  logic             push_rdy;
  etx_word_s        head;
  logic             head_v;
  logic             pop;
  logic [4:0]       eop_cnt_q;
  etx_state_e       state_q;
  etx_state_e       state_d;
  logic [3:0]       cnt_q;
  logic [2:0]       bi_q;
  logic [15:0]      len_q;
  logic             err_q;
  logic [7:0]       ob;
  logic             oc;
  logic             take;
  logic             last_b;
  logic             crc_init;
  logic             crc_en;
  logic [31:0]      crc;
  logic [2:0]       ln_q;
  etx_xgmii_s       acc_q;
  logic             valid_q;

  // Highest pending word is the earliest on the wire.
  function automatic logic [WORDS-1:0] top_one(input logic [WORDS-1:0] v);
    logic [WORDS-1:0] r;
    r = '0;
    for (int i = 0; i < WORDS; i++) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  assign din_req_out = (hold_v_q == '0);
  assign sel         = top_one(hold_v_q);
  assign push_v      = (hold_v_q != '0);

  always_comb begin
    push_w = '0;
    for (int i = 0; i < WORDS; i++) begin
      if (sel[i]) begin
        push_w = hold_q[i];
      end
    end
  end

  // The holding stage trades rate for simplicity: one word per cycle enters the FIFO.
  generate
    for (genvar g = 0; g < WORDS; g++) begin : g_hold
      always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
          hold_q[g]   <= '0;
          hold_v_q[g] <= 1'b0;
        end else if (ce_in) begin
          if (din_req_out) begin
            hold_q[g].data  <= din_in[g*WORD_BITS +: WORD_BITS];
            hold_q[g].sop   <= din_sop_in[g];
            hold_q[g].eop   <= din_eop_in[g];
            hold_q[g].empty <= din_eop_empty_in[g*3 +: 3];
            hold_q[g].err   <= tx_error_in[g] && din_eop_in[g];
            hold_v_q[g]     <= !din_idle_in[g];
          end else if (sel[g] && push_rdy) begin
            hold_v_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  etx_fifo #(
    .WIDTH (WB),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .in_valid_in   (push_v),
    .in_ready_out  (push_rdy),
    .in_data_in    (push_w),
    .out_valid_out (head_v),
    .out_ready_in  (pop),
    .out_data_out  (head)
  );

  // Complete packets waiting; a packet starts only when one is whole or the FIFO is full.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      eop_cnt_q <= '0;
    end else if (ce_in) begin
      eop_cnt_q <= eop_cnt_q + 5'(push_v && push_rdy && push_w.eop)
                             - 5'(pop && head.eop);
    end
  end

  assign last_b = head.eop ? (bi_q == 3'(3'd7 - head.empty)) : (bi_q == 3'd7);
  assign take   = (state_q == S_DATA) || (state_q == S_PRE && PREAMBLE_PASS);
  assign pop    = take && head_v && last_b;

  always_comb begin
    state_d  = state_q;
    ob       = CHAR_IDLE;
    oc       = 1'b1;
    crc_init = 1'b0;
    crc_en   = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        crc_init = 1'b1;
        // idles until ready
        // Leaving idle on the last lane puts the start mark in lane 0.
        if (ln_q == 3'd7 && head_v && (eop_cnt_q != '0 || !push_rdy)) begin
          state_d = S_PRE;
        end
      end
      S_PRE: begin
        oc = (cnt_q == 4'h0);
        if (PREAMBLE_PASS) begin
          ob = (cnt_q == 4'h0) ? CHAR_START : head.data[8*(7-bi_q) +: 8];
        end else begin
          ob = (cnt_q == 4'h0) ? CHAR_START :
               (cnt_q == PRE_LAST) ? START_DELIM : PREAMBLE_B;
        end
        if (cnt_q == PRE_LAST) begin
          state_d = S_DATA;
        end
      end
      S_DATA: begin
        ob     = head.data[8*(7-bi_q) +: 8];
        oc     = 1'b0;
        crc_en = 1'b1;
        if (head.eop && last_b) begin
          state_d = (len_q + 16'h0001 < MIN_PAYLOAD) ? S_PAD : S_FCS;
        end
      end
      S_PAD: begin
        ob     = 8'h00;
        oc     = 1'b0;
        crc_en = 1'b1;
        if (len_q + 16'h0001 >= MIN_PAYLOAD) begin
          state_d = S_FCS;
        end
      end
      S_FCS: begin
        ob = ~crc[8*cnt_q[1:0] +: 8] ^ {8{err_q}};
        oc = 1'b0;
        if (cnt_q == FCS_LAST) begin
          state_d = S_TERM;
        end
      end
      S_TERM: begin
        ob      = CHAR_TERM;
        state_d = S_IPG;
      end
      S_IPG: begin
        if (cnt_q == IPG_LAST) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
    end else if (ce_in) begin
      state_q <= state_d;
      cnt_q   <= (state_d != state_q) ? 4'h0 : cnt_q + 4'h1;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      bi_q <= '0;
    end else if (ce_in && take) begin
      bi_q <= last_b ? 3'd0 : bi_q + 3'd1;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      len_q <= '0;
      err_q <= 1'b0;
    end else if (ce_in) begin
      if (state_q == S_IDLE) begin
        len_q <= '0;
        err_q <= 1'b0;
      end else if (crc_en) begin
        len_q <= len_q + 16'h0001;
        if (state_q == S_DATA && head.eop && last_b) begin
          err_q <= head.err;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      dest_multicast_out <= 1'b0;
      dest_local_out     <= 1'b0;
    end else if (ce_in && state_q == S_DATA && len_q == '0) begin
      dest_multicast_out <= ob[0];
      dest_local_out     <= ob[1];
    end
  end

  etx_crc32 u_crc (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .init_in  (crc_init),
    .en_in    (crc_en),
    .byte_in  (ob),
    .crc_out  (crc)
  );

  // The lane order itself is the bit reversal: lane 0 goes first, each octet bit 0 first.
  // little-endian lanes
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      ln_q            <= '0;
      acc_q           <= '0;
      xgmii_out       <= '{data: {8{CHAR_IDLE}}, ctrl: 8'hFF};
      valid_q         <= 1'b0;
    end else if (ce_in) begin
      ln_q                   <= ln_q + 3'd1;
      acc_q.data[8*ln_q +: 8] <= ob;
      acc_q.ctrl[ln_q]       <= oc;
      valid_q                <= (ln_q == 3'd7);
      if (ln_q == 3'd7) begin
        xgmii_out.data <= {ob, acc_q.data[55:0]};
        xgmii_out.ctrl <= {oc, acc_q.ctrl[6:0]};
      end
    end
  end

  // A frozen enable must not repeat the pulse, so the held flag is gated here.
  assign xgmii_valid_out = valid_q && ce_in;
endmodule

/* verification/etx_mac_tx_props.sv */
`timescale 1ns/1ps
module etx_mac_tx_props import etx_pkg::*; #(
  parameter int unsigned WORDS         = 4,
  parameter bit          PREAMBLE_PASS = 1'b0
) (
  // Clock and reset
  input wire logic             mclk_in,
  input wire logic             reset_in,
  input wire logic             ce_in,
  // Client side
  input wire logic [WORDS-1:0] din_idle_in,
  input wire logic             din_req_out,
  // PHY side
  input wire etx_xgmii_s       xgmii_out,
  input wire logic             xgmii_valid_out
);
  logic       fb_lo, fb_hi, fd_any, tail_bad, in_frame_q, seen_q;
  logic [3:0] gap_q;
  logic       end_q;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  always_comb begin
    fb_lo = xgmii_out.ctrl[0] && xgmii_out.data[7:0] == CHAR_START;
    fb_hi = 1'b0;
    fd_any = 1'b0;
    tail_bad = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (fd_any && !(xgmii_out.ctrl[k] && xgmii_out.data[8*k +: 8] == CHAR_IDLE))
        tail_bad = 1'b1;
      if (xgmii_out.ctrl[k] && xgmii_out.data[8*k +: 8] == CHAR_TERM)
        fd_any = 1'b1;
      if (k > 0 && xgmii_out.ctrl[k] && xgmii_out.data[8*k +: 8] == CHAR_START)
        fb_hi = 1'b1;
    end
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in)
      in_frame_q <= 1'b0;
    else if (xgmii_valid_out)
      in_frame_q <= fd_any ? 1'b0 : (fb_lo | in_frame_q);
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in)
      seen_q <= 1'b0;
    else if (xgmii_valid_out)
      seen_q <= 1'b1;
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in)
      end_q <= 1'b0;
    else if (xgmii_valid_out)
      end_q <= fd_any;
  end
  // Saturates so that a long stall cannot wrap round to the expected spacing.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in)
      gap_q <= 4'h0;
    else if (xgmii_valid_out)
      gap_q <= 4'h0;
    else if (ce_in && gap_q != 4'hF)
      gap_q <= gap_q + 4'h1;
  end
  a_block_cadence: assert property (xgmii_valid_out |-> !seen_q || gap_q == 4'h7)
    else $error("block pulse spacing wrong");
  a_block_holds: assert property ($changed(xgmii_out) |-> xgmii_valid_out || !ce_in)
    else $error("lanes changed between pulses");
  a_take_drops_req: assert property (
    din_req_out && ce_in && din_idle_in != '1 |=> !din_req_out)
    else $error("accept stayed high after a take");
  a_start_lane_zero: assert property (xgmii_valid_out |-> !fb_hi)
    else $error("start mark outside lane zero");
  a_preamble_first: assert property (
    xgmii_valid_out && fb_lo && !PREAMBLE_PASS |->
    {xgmii_out.data, xgmii_out.ctrl} == 72'hD5_5555_5555_5555_FB01)
    else $error("start block is not the preamble");
  a_no_inner_idle: assert property (
    xgmii_valid_out && in_frame_q && !fd_any |-> xgmii_out.ctrl == 8'h00)
    else $error("control byte inside a frame");
  a_gap_after_end: assert property (
    xgmii_valid_out && end_q |-> !fb_lo)
    else $error("frame started inside the gap");
  a_idle_tail: assert property (xgmii_valid_out && fd_any |-> !tail_bad)
    else $error("lanes after end mark not idle");
  c_frame_start: cover property (xgmii_valid_out && fb_lo);
  c_frame_end: cover property (xgmii_valid_out && fd_any);
  c_refused: cover property (!din_req_out [*3]);
endmodule
bind etx_mac_tx etx_mac_tx_props #(.WORDS(WORDS), .PREAMBLE_PASS(PREAMBLE_PASS))
  i_etx_mac_tx_props (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_in),
  .din_idle_in(din_idle_in), .din_req_out(din_req_out), .xgmii_out(xgmii_out),
  .xgmii_valid_out(xgmii_valid_out));

/* verification/etx_phy_sink.sv */
`timescale 1ns/1ps
module etx_phy_sink import etx_pkg::*; (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Lanes from the transmitter
  input  wire etx_xgmii_s xgmii_in,
  input  wire logic       valid_in,
  // Fault count
  output int              bad_out
);
  logic [8:0] rx_q[$];
  logic [8:0] b;
  bit         in_frame, seen;
  int         gap;
  initial bad_out = 0;
  always @(posedge mclk_in) begin
    if (!reset_in && valid_in) begin
      for (int k = 0; k < 8; k++) begin
        b = {xgmii_in.ctrl[k], xgmii_in.data[8*k +: 8]};
        if (b == {1'b1, CHAR_START}) begin
          if (seen && gap < 12)
            bad_out++;
          in_frame = 1'b1;
          seen = 1'b1;
        end
        if (in_frame && b[8] && b != {1'b1, CHAR_START} && b != {1'b1, CHAR_TERM})
          bad_out++;
        if (in_frame)
          rx_q.push_back(b);
        if (b == {1'b1, CHAR_TERM}) begin
          in_frame = 1'b0;
          gap = 0;
        end else if (!in_frame) begin
          gap++;
        end
      end
    end
  end
endmodule

/* verification/etx_mac_tx_test.sv */
`timescale 1ns/1ps
module etx_mac_tx_test import etx_pkg::*; ;
  logic [255:0] din_in;
  logic [3:0]   din_sop_in, din_eop_in, din_idle_in, tx_error_in;
  logic [11:0]  din_eop_empty_in;
  logic         mclk_in, reset_in, din_req_out, xgmii_valid_out;
  logic         dest_multicast_out, dest_local_out;
  logic         ce_in = 1'b1;
  etx_xgmii_s   xgmii_out;
  logic [8:0]   exp_q[$];
  logic [1:0]   flag_q[$];
  logic [7:0]   pkt[256];
  int           len_q[$];
  int           err_total, total_checks, bad_cnt, cyc, seed_v;
  int           sz[7] = '{9, 60, 61, 200, 17, 64, 130};

  etx_mac_tx #(.WORDS(4)) i_etx_mac_tx (
    .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_in), .din_in(din_in),
    .din_sop_in(din_sop_in), .din_eop_in(din_eop_in), .din_eop_empty_in(din_eop_empty_in),
    .din_idle_in(din_idle_in), .tx_error_in(tx_error_in), .din_req_out(din_req_out),
    .xgmii_out(xgmii_out), .xgmii_valid_out(xgmii_valid_out),
    .dest_multicast_out(dest_multicast_out), .dest_local_out(dest_local_out));
  etx_phy_sink i_etx_phy_sink (.mclk_in(mclk_in), .reset_in(reset_in), .xgmii_in(xgmii_out),
    .valid_in(xgmii_valid_out), .bad_out(bad_cnt));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  // Random stalls show that a low enable freezes every stage.
  always @(posedge mclk_in) begin
    #1;
    ce_in = ($urandom_range(7, 0) != 0);
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_byte(input string what, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_flag(input string what, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  // Idle words carry garbage so that ignored inputs are really exercised.
  task automatic idle_bus;
    for (int j = 0; j < 8; j++)
      din_in[32*j +: 32] = $urandom();
    din_idle_in = 4'hF;
    din_sop_in = 4'h0;
    din_eop_in = 4'h0;
    din_eop_empty_in = 12'($urandom());
    tx_error_in = 4'($urandom());
  endtask

  task automatic send_pkt(input int n, input bit err, input int pos);
    int         w, p, i, b;
    logic [31:0] crc;
    logic [7:0] v;
    bit         tk;
    w = (n + 7) / 8;
    for (i = 0; i < n; i++)
      pkt[i] = 8'($urandom());
    exp_q.push_back(9'h1FB);
    repeat (6) exp_q.push_back(9'h055);
    exp_q.push_back(9'h0D5);
    crc = 32'hFFFF_FFFF;
    for (i = 0; i < 60 || i < n; i++) begin
      v = (i < n) ? pkt[i] : 8'h00;
      exp_q.push_back({1'b0, v});
      crc = crc ^ {24'h00_0000, v};
      for (b = 0; b < 8; b++)
        crc = crc[0] ? ((crc >> 1) ^ 32'hEDB8_8320) : (crc >> 1);
    end
    crc = err ? crc : ~crc;
    for (b = 0; b < 4; b++)
      exp_q.push_back({1'b0, crc[8*b +: 8]});
    exp_q.push_back(9'h1FD);
    len_q.push_back(13 + (n > 60 ? n : 60));
    flag_q.push_back(pkt[0][1:0]);
    for (i = 0; i < w; i++) begin
      idle_bus();
      p = (i == 0) ? pos : $urandom_range(3, 0);
      din_idle_in[p] = 1'b0;
      for (b = 0; b < 8; b++)
        din_in[p*64 + 56 - 8*b +: 8] = (i*8 + b < n) ? pkt[i*8 + b] : 8'($urandom());
      din_sop_in[p] = (i == 0);
      din_eop_in[p] = (i == w - 1);
      din_eop_empty_in[3*p +: 3] = 3'(w*8 - n);
      tx_error_in[p] = err && (i == w - 1);
      do begin
        @(negedge mclk_in);
        tk = din_req_out && ce_in;
        @(posedge mclk_in);
      end while (tk !== 1'b1);
      #1;
    end
    idle_bus();
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    int n;
    forever begin
      @(posedge mclk_in);
      #2;
      if (len_q.size() != 0 && i_etx_phy_sink.rx_q.size() >= len_q[0]) begin
        n = len_q.pop_front();
        repeat (n) chk_byte("lane byte", exp_q.pop_front(), i_etx_phy_sink.rx_q.pop_front());
        chk_flag("address flags", flag_q.pop_front(), {dest_local_out, dest_multicast_out});
      end
    end
  end

  initial begin
    seed_v = $urandom(85);
    reset_in = 1'b1;
    idle_bus();
    repeat (6) @(posedge mclk_in);
    #1;
    for (int k = 0; k < 8; k++)
      chk_byte("reset lane", 9'h107, {xgmii_out.ctrl[k], xgmii_out.data[8*k +: 8]});
    reset_in = 1'b0;
    @(posedge mclk_in);
    #1;
    for (int k = 0; k < 14; k++) begin
      send_pkt(k < 7 ? sz[k] : int'($urandom_range(120, 9)), k == 3 || k == 10, k % 4);
      #(5 * ((k % 3 == 0) ? 0 : $urandom_range(150, 1)));
    end
    while (len_q.size() != 0)
      @(posedge mclk_in);
    chk_byte("sink faults", 9'h000, {8'h00, bad_cnt != 0});
    wrap_up();
  end
endmodule
